/* core/afs_pkg.sv */
// Shared constants and types for the serial mode control block.
package afs_pkg;
    // Control register indices, eight registers of eight bits.
    localparam logic [2:0] REG_A = 3'h0;
    localparam logic [2:0] REG_B = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_D = 3'h3;
    localparam logic [2:0] REG_F = 3'h5;
    localparam int NUM_REGS = 8;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    // Field positions in control register A.
    localparam int A_MODE_SEL = 0;
    localparam int A_MIXED = 1;
    localparam int A_SOFT_RST = 7;
    // Field positions in control register B.
    localparam int B_DR_LO = 0;
    localparam int B_SCD_LO = 2;
    localparam int B_MCD_LO = 4;
    // Field positions in control register C.
    localparam int C_GLOBAL_PWR = 0;
    localparam int C_REF_PWR = 5;
    // Channel power bit inside each nibble of registers D to F.
    localparam int CH_PWR_BIT = 3;
    // Timing counts.
    localparam int RESET_DM_CYCLES = 4;
    localparam int STARTUP_MCLK_CYCLES = 2070;
    localparam int SCLK_SLOW_DIV = 8;
    localparam int SAMPLE_SLOW_DIV = 2048;
    localparam int WORD_BITS = 16;
    localparam int NUM_CHANNELS = 6;
    localparam int MCD_MAX = 5;
    // Control word as it arrives on the serial input.
    typedef struct packed {
        logic ctrl_flag;
        logic rd_wr;
        logic [2:0] dev_addr;
        logic [2:0] reg_addr;
        logic [7:0] reg_data;
    } afs_ctrl_word_t;
    // Transmit state.
    typedef enum logic [1:0] {
        AFS_TX_IDLE,
        AFS_TX_LEAD,
        AFS_TX_SLOT
    } afs_tx_state_t;
endpackage : afs_pkg

/* core/afs_serial_ctrl.sv */
// Serial port mode control of a six-channel sampling front end.
//
// How it works
// - Reset clears all registers, slowest clock rates.
// - Writing register A bit 7 resets registers.
// - Both resets last four divided-clock cycles.
// - Reset selects program mode; no valid samples.
// - First frame sync about 2070 clocks after reset.
// - Global power bit overrides; reference keeps own bit.
// - Register writes only in program or mixed mode.
// - Every transfer is one 16-bit word.
// - Program mode: address zero word is ours.
// - Nonzero address: decrement and forward word out.
// - Frame sync at slowest rate until B written.
// - Mode bit set, mixed clear: ignore input.
// - Data mode locks registers until hardware reset.
// - Mixed mode: input MSB set marks control.
// - Mixed mode: sample words go out MSB clear.
// - Mixed mode may be the first write.
// - Channel power changes in mixed, not data mode.
// - Frame sync high one bit before word.
// - Device drives the serial bit clock.
// - Register writes latch on serial clock falling edge.
// - Powered-down slot: no data, output released.
`timescale 1ns/100ps
`default_nettype none
module afs_serial_ctrl #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial port pins.
    input wire logic port_enable_pin,
    input wire logic serial_in_line,
    input wire logic in_frame_sync,
    output logic serial_clk,
    output logic out_frame_sync,
    output logic serial_out_line,
    output logic serial_out_oe,
    // Converter sample stream.
    input wire logic adc_valid,
    input wire logic [WIDTH-1:0] adc_data,
    output logic adc_ready,
    // Configuration and status.
    output logic [8*afs_pkg::NUM_REGS-1:0] ctrl_regs,
    output logic [afs_pkg::NUM_CHANNELS-1:0] chan_power,
    output logic ref_power,
    output logic data_mode,
    output logic mixed_mode,
    output logic reset_busy
);
    localparam int PW = $clog2(DEPTH);

    // Master clock divide ratio from the divider field; unused codes give one.
    function automatic logic [2:0] mcd_ratio(input logic [2:0] code);
        return (code <= 3'h4) ? 3'(code + 3'h1) : 3'h1;
    endfunction : mcd_ratio
    // Registers, rate dividers, reset sequencer and startup delay.
    logic [7:0] cr_r [afs_pkg::NUM_REGS];
    logic [2:0] mdiv_r, sdiv_r, rst_cnt_r;
    logic [10:0] sdec_r;
    logic [11:0] start_cnt_r;
    logic dm_tick_r, bit_tick_r, sample_tick_r, busy_r, started_r, lock_r, serial_clk_r;
    // Receiver, two-entry buffer, transmitter, power and mode.
    logic rx_act_r, rx_done_r, fifo_push, fifo_pop, fwd_req, wr_req, soft_rst;
    logic [3:0] rx_cnt_r, tx_bit_r;
    logic [WIDTH-1:0] rx_sh_r, fifo_din, tx_sh_r;
    afs_pkg::afs_ctrl_word_t rx_word;
    logic [WIDTH-1:0] fifo_mem_r [DEPTH];
    logic [PW-1:0] fifo_wp_r, fifo_rp_r;
    logic [PW:0] fifo_cnt_r;
    afs_pkg::afs_tx_state_t tx_state_r;
    logic [2:0] tx_slot_r;
    logic [afs_pkg::NUM_CHANNELS-1:0] pwr_r;
    logic frame_pend_r, ref_r, fs_r, sdo_r, oe_r, mode_sel, mixed;
    assign mode_sel = cr_r[afs_pkg::REG_A][afs_pkg::A_MODE_SEL];
    assign mixed = cr_r[afs_pkg::REG_A][afs_pkg::A_MIXED];
    assign rx_word = rx_sh_r;

    // Divided master clock enable; ratio follows register B.
    always_ff @(posedge core_clk) begin
        dm_tick_r <= 1'b0;
        if (rst) begin
            mdiv_r <= 3'h0;
        end else if (mdiv_r + 3'h1 >= mcd_ratio(cr_r[afs_pkg::REG_B][afs_pkg::B_MCD_LO +: 3])) begin
            mdiv_r <= 3'h0;
            dm_tick_r <= 1'b1;
        end else begin
            mdiv_r <= mdiv_r + 3'h1;
        end
    end

    // Bit rate and sample rate enables, both counted in divided clocks.
    // A zeroed register B leaves the slowest ratios in force.
    always_ff @(posedge core_clk) begin
        bit_tick_r <= 1'b0;
        sample_tick_r <= 1'b0;
        if (rst) begin
            sdiv_r <= 3'h0;
            sdec_r <= 11'h000;
        end else if (dm_tick_r) begin
            if (sdiv_r >= 3'((afs_pkg::SCLK_SLOW_DIV >> cr_r[afs_pkg::REG_B][afs_pkg::B_SCD_LO +: 2]) - 1)) begin
                sdiv_r <= 3'h0;
                bit_tick_r <= 1'b1;
            end else begin
                sdiv_r <= sdiv_r + 3'h1;
            end
            if (sdec_r >= 11'((afs_pkg::SAMPLE_SLOW_DIV >> cr_r[afs_pkg::REG_B][afs_pkg::B_DR_LO +: 2]) - 1)) begin
                sdec_r <= 11'h000;
                sample_tick_r <= 1'b1;
            end else begin
                sdec_r <= sdec_r + 11'h001;
            end
        end
    end

    // Reset sequencer: hardware or software reset holds for four divided clocks.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rst_cnt_r <= 3'h0;
            busy_r <= 1'b1;
        end else if (soft_rst) begin
            rst_cnt_r <= 3'h0;
            busy_r <= 1'b1;
        end else if (busy_r && dm_tick_r) begin
            rst_cnt_r <= rst_cnt_r + 3'h1;
            busy_r <= (rst_cnt_r + 3'h1) < 3'(afs_pkg::RESET_DM_CYCLES);
        end
    end

    // Startup delay before the first output frame after the reset pin falls.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            start_cnt_r <= 12'h000;
            started_r <= 1'b0;
        end else if (!started_r) begin
            start_cnt_r <= start_cnt_r + 12'h001;
            started_r <= (start_cnt_r + 12'h001) >= 12'(afs_pkg::STARTUP_MCLK_CYCLES);
        end
    end

    // Output bit clock: a high pulse per bit, inputs taken as it falls.
    // At the fastest ratio the pulses merge and the line stays high.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            serial_clk_r <= 1'b0;
        end else begin
            serial_clk_r <= bit_tick_r;
        end
    end

    // Receiver: sixteen bits after an input frame sync, back to back allowed.
    always_ff @(posedge core_clk) begin
        rx_done_r <= 1'b0;
        if (rst) begin
            rx_act_r <= 1'b0;
            rx_cnt_r <= 4'h0;
            rx_sh_r <= '0;
        end else if (serial_clk_r) begin
            if (rx_act_r) begin
                rx_sh_r <= {rx_sh_r[WIDTH-2:0], serial_in_line};
                rx_cnt_r <= rx_cnt_r + 4'h1;
                if (rx_cnt_r == 4'(afs_pkg::WORD_BITS - 1)) begin
                    rx_done_r <= 1'b1;
                    rx_act_r <= in_frame_sync;
                end
            end else if (in_frame_sync) begin
                rx_act_r <= 1'b1;
                rx_cnt_r <= 4'h0;
            end
        end
    end

    // Word decode: program mode takes all words, mixed mode only flagged ones.
    always_comb begin
        wr_req = 1'b0;
        fwd_req = 1'b0;
        if (rx_done_r && !busy_r && !lock_r && (!mode_sel || (mixed && rx_word.ctrl_flag))) begin
            wr_req = rx_word.dev_addr == 3'h0;
            fwd_req = rx_word.dev_addr != 3'h0;
        end
    end
    assign soft_rst = wr_req && rx_word.reg_addr == afs_pkg::REG_A && rx_word.reg_data[afs_pkg::A_SOFT_RST];

    // Control registers; mixed mode may be chosen by the very first write.
    always_ff @(posedge core_clk) begin
        if (rst || soft_rst) begin
            for (int i = 0; i < afs_pkg::NUM_REGS; i++) begin
                cr_r[i] <= afs_pkg::REG_RESET_VAL;
            end
        end else if (wr_req) begin
            cr_r[rx_word.reg_addr] <= rx_word.reg_data;
        end
    end

    // Plain data mode locks the registers until the reset pin.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            lock_r <= 1'b0;
        end else if (mode_sel && !mixed) begin
            lock_r <= 1'b1;
        end
    end

    // Effective power: global bit wins; reference keeps its own bit or any channel.
    // In data mode the lock freezes the power bits with the registers.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_r <= '0;
            ref_r <= 1'b0;
        end else begin
            for (int c = 0; c < afs_pkg::NUM_CHANNELS; c++) begin
                pwr_r[c] <= cr_r[afs_pkg::REG_C][afs_pkg::C_GLOBAL_PWR]
                    || cr_r[afs_pkg::REG_D + 3'(c / 2)][afs_pkg::CH_PWR_BIT + 4 * (c % 2)];
            end
            ref_r <= cr_r[afs_pkg::REG_C][afs_pkg::C_GLOBAL_PWR]
                || cr_r[afs_pkg::REG_C][afs_pkg::C_REF_PWR]
                || ((cr_r[afs_pkg::REG_D] | cr_r[afs_pkg::REG_D + 3'h1] | cr_r[afs_pkg::REG_F])
                & (8'h11 << afs_pkg::CH_PWR_BIT)) != 8'h00;
        end
    end
    // Two-entry buffer: forwarded words take priority over samples.
    // Samples are taken only in data or mixed mode and held back when full.
    always_comb begin
        fifo_push = 1'b0;
        fifo_din = adc_data;
        if (fwd_req) begin
            fifo_push = fifo_cnt_r != (PW + 1)'(DEPTH);
            fifo_din = {rx_word.ctrl_flag, rx_word.rd_wr, rx_word.dev_addr - 3'h1,
                rx_word.reg_addr, rx_word.reg_data};
        end else if (adc_valid && adc_ready) begin
            fifo_push = 1'b1;
            fifo_din = mixed ? {1'b0, adc_data[WIDTH-2:0]} : adc_data;
        end
    end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fifo_wp_r <= '0;
            fifo_rp_r <= '0;
            fifo_cnt_r <= '0;
        end else begin
            if (fifo_push) begin
                fifo_mem_r[fifo_wp_r] <= fifo_din;
                fifo_wp_r <= (fifo_wp_r == PW'(DEPTH - 1)) ? '0 : fifo_wp_r + PW'(1);
            end
            if (fifo_pop) begin
                fifo_rp_r <= (fifo_rp_r == PW'(DEPTH - 1)) ? '0 : fifo_rp_r + PW'(1);
            end
            fifo_cnt_r <= fifo_cnt_r + (PW + 1)'(fifo_push) - (PW + 1)'(fifo_pop);
        end
    end
    // Ready is registered: high one cycle after a pop frees room, and low while a word is decoded,
    // so that a forwarded word never meets a sample that was already handed over.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            adc_ready <= 1'b0;
        end else begin
            adc_ready <= mode_sel && !busy_r
                && !(serial_clk_r && rx_act_r && rx_cnt_r == 4'(afs_pkg::WORD_BITS - 1))
                && (fifo_cnt_r + (PW + 1)'(fifo_push) - (PW + 1)'(fifo_pop)) < (PW + 1)'(DEPTH);
        end
    end
    // Slot activity: program mode sends one word, else powered channels only.
    function automatic logic slot_on(input logic [2:0] s, input logic ms,
                                     input logic [afs_pkg::NUM_CHANNELS-1:0] p);
        return ms ? p[s] : (s == 3'h0);
    endfunction : slot_on
    assign fifo_pop = bit_tick_r && fifo_cnt_r != '0 && slot_on(tx_slot_r, mode_sel, pwr_r)
        && ((tx_state_r == afs_pkg::AFS_TX_LEAD)
        || (tx_state_r == afs_pkg::AFS_TX_SLOT && tx_bit_r == 4'hf
        && tx_slot_r != 3'(afs_pkg::NUM_CHANNELS - 1) && slot_on(tx_slot_r + 3'h1, mode_sel, pwr_r)));

    // Frame request as the startup delay ends, then on each sample tick while enabled.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            frame_pend_r <= 1'b0;
        end else if (port_enable_pin && !busy_r && ((sample_tick_r && started_r)
            || start_cnt_r == 12'(afs_pkg::STARTUP_MCLK_CYCLES - 1))) begin
            frame_pend_r <= 1'b1;
        end else if (bit_tick_r && tx_state_r == afs_pkg::AFS_TX_IDLE) begin
            frame_pend_r <= 1'b0;
        end
    end
    // Transmitter: lead bit with frame sync, then one word per slot.
    // The slot index points at the slot about to be loaded while in the lead bit.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_state_r <= afs_pkg::AFS_TX_IDLE;
            tx_slot_r <= 3'h0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= '0;
            fs_r <= 1'b0;
            sdo_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (bit_tick_r) begin
            fs_r <= 1'b0;
            unique case (tx_state_r)
                afs_pkg::AFS_TX_IDLE: begin
                    oe_r <= 1'b0;
                    if (frame_pend_r) begin
                        tx_state_r <= afs_pkg::AFS_TX_LEAD;
                        tx_slot_r <= 3'h0;
                        fs_r <= slot_on(3'h0, mode_sel, pwr_r);
                    end
                end
                afs_pkg::AFS_TX_LEAD: begin
                    tx_state_r <= afs_pkg::AFS_TX_SLOT;
                    tx_bit_r <= 4'h0;
                    tx_sh_r <= {(fifo_pop ? fifo_mem_r[fifo_rp_r][WIDTH-2:0] : '0), 1'b0};
                    sdo_r <= fifo_pop ? fifo_mem_r[fifo_rp_r][WIDTH-1] : 1'b0;
                    oe_r <= slot_on(3'h0, mode_sel, pwr_r);
                end
                afs_pkg::AFS_TX_SLOT: begin
                    if (tx_bit_r == 4'hf) begin
                        if (tx_slot_r == 3'(afs_pkg::NUM_CHANNELS - 1) || !mode_sel) begin
                            tx_state_r <= afs_pkg::AFS_TX_IDLE;
                            oe_r <= 1'b0;
                        end else begin
                            tx_slot_r <= tx_slot_r + 3'h1;
                            tx_bit_r <= 4'h0;
                            tx_sh_r <= {(fifo_pop ? fifo_mem_r[fifo_rp_r][WIDTH-2:0] : '0), 1'b0};
                            sdo_r <= fifo_pop ? fifo_mem_r[fifo_rp_r][WIDTH-1] : 1'b0;
                            oe_r <= slot_on(tx_slot_r + 3'h1, mode_sel, pwr_r);
                        end
                    end else begin
                        tx_bit_r <= tx_bit_r + 4'h1;
                        sdo_r <= tx_sh_r[WIDTH-1];
                        tx_sh_r <= {tx_sh_r[WIDTH-2:0], 1'b0};
                        // Back to back: sync rides on the last bit of the word.
                        fs_r <= tx_bit_r == 4'he && mode_sel
                            && tx_slot_r != 3'(afs_pkg::NUM_CHANNELS - 1)
                            && slot_on(tx_slot_r + 3'h1, mode_sel, pwr_r);
                    end
                end
            endcase
        end
    end

    // Register mirrors for the configuration and status outputs.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_regs <= '0;
            data_mode <= 1'b0;
            mixed_mode <= 1'b0;
        end else begin
            for (int i = 0; i < afs_pkg::NUM_REGS; i++) begin
                ctrl_regs[8*i +: 8] <= cr_r[i];
            end
            data_mode <= mode_sel;
            mixed_mode <= mode_sel && mixed;
        end
    end

    assign serial_clk = serial_clk_r;
    assign out_frame_sync = fs_r;
    assign serial_out_line = sdo_r;
    assign serial_out_oe = oe_r;
    assign chan_power = pwr_r;
    assign ref_power = ref_r;
    assign reset_busy = busy_r;
endmodule : afs_serial_ctrl
`default_nettype wire

/* sim/afs_serial_ctrl_checker.sv */
// Port-level assertions for the serial mode control block.
`timescale 1ns/100ps
`default_nettype none
module afs_serial_ctrl_checker (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst,
    // Serial port outputs.
    input wire logic serial_clk,
    input wire logic out_frame_sync,
    input wire logic serial_out_oe,
    input wire logic adc_ready,
    // Configuration and status.
    input wire logic [63:0] ctrl_regs,
    input wire logic [5:0] chan_power,
    input wire logic ref_power,
    input wire logic data_mode,
    input wire logic mixed_mode,
    input wire logic reset_busy
);
    logic [11:0] since_rst_r;
    logic seen_fs_r;
    logic [3:0] gap_r;
    logic tick_seen_r;
    logic [5:0] pwr_exp;
    // Age since reset and bit clock spacing; a reset restarts the divider, so spacing waits.
    always_ff @(posedge core_clk) begin
        since_rst_r <= rst ? 12'h000 : since_rst_r + {11'h000, since_rst_r != 12'hfff};
        seen_fs_r <= !rst && (seen_fs_r || out_frame_sync);
        gap_r <= serial_clk ? 4'h0 : gap_r + 4'h1;
        tick_seen_r <= !rst && !reset_busy && (tick_seen_r || serial_clk);
    end
    // Channel power that the mirrored registers call for.
    assign pwr_exp = ctrl_regs[16] ? 6'h3f : {ctrl_regs[47], ctrl_regs[43], ctrl_regs[39],
        ctrl_regs[35], ctrl_regs[31], ctrl_regs[27]};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_clears: assert property ($fell(rst) |-> ctrl_regs == '0 && reset_busy)
        else $error("registers not clear after reset");
    a_busy_four: assert property ($fell(rst) |-> reset_busy [*3] ##[1:3] !reset_busy)
        else $error("reset busy length wrong");
    a_first_frame: assert property (out_frame_sync && !seen_fs_r |-> since_rst_r >= 12'h815)
        else $error("first frame sync too early");
    a_ready_prog: assert property (!data_mode ##1 !data_mode |-> !adc_ready)
        else $error("samples taken in program mode");
    a_mixed_mode: assert property (mixed_mode |-> data_mode)
        else $error("mixed mode without mode select");
    a_power_map: assert property ($stable(ctrl_regs) [*2] |-> chan_power == pwr_exp)
        else $error("channel power wrong");
    a_ref_power: assert property ($stable(ctrl_regs) [*2] |->
        ref_power == (ctrl_regs[16] | ctrl_regs[21] | (|pwr_exp)))
        else $error("reference power wrong");
    a_data_lock: assert property ((data_mode && !mixed_mode) [*2] |=> $stable(ctrl_regs))
        else $error("registers changed in data mode");
    a_frame_lead: assert property ($rose(out_frame_sync) && !serial_out_oe |->
        ##[1:40] ($rose(serial_out_oe) && $fell(out_frame_sync)))
        else $error("frame sync not one bit ahead");
    a_bit_clock: assert property (serial_clk && tick_seen_r && ctrl_regs[15:8] == 8'h00 |->
        gap_r == 4'h7)
        else $error("bit clock not at slowest ratio");
endmodule : afs_serial_ctrl_checker
bind afs_serial_ctrl afs_serial_ctrl_checker afs_serial_ctrl_checker_i (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .out_frame_sync(out_frame_sync),
    .serial_out_oe(serial_out_oe), .adc_ready(adc_ready), .ctrl_regs(ctrl_regs),
    .chan_power(chan_power), .ref_power(ref_power), .data_mode(data_mode),
    .mixed_mode(mixed_mode), .reset_busy(reset_busy));
`default_nettype wire

/* sim/afs_host_port.sv */
// Behavioural host serial port that sends and receives 16-bit words.
`timescale 1ns/100ps
`default_nettype none
module afs_host_port (
    // Clock and the block's bit clock.
    input wire logic core_clk,
    input wire logic serial_clk,
    // Send request from the bench.
    input wire logic tx_go,
    input wire logic [15:0] tx_word,
    output logic tx_busy,
    // Lines toward and from the block.
    output logic serial_in_line = 1'b0,
    output logic in_frame_sync = 1'b0,
    input wire logic serial_out_line,
    input wire logic serial_out_oe,
    input wire logic out_frame_sync,
    // Received words, one strobe each.
    output logic rx_stb = 1'b0,
    output logic [15:0] rx_word = 16'h0000
);
    logic [4:0] tcnt = 5'h00;
    logic [4:0] rcnt = 5'h00;
    logic [15:0] tsh = 16'h0000;
    assign tx_busy = tcnt != 5'h00;
    // Send: sync one bit ahead of the MSB; the idle line flips so no stale bit lingers.
    always @(posedge core_clk) begin
        if (serial_clk && tcnt == 5'h00 && tx_go) begin
            in_frame_sync <= 1'b1;
            tsh <= tx_word;
            tcnt <= 5'h11;
        end else if (serial_clk && tcnt != 5'h00) begin
            in_frame_sync <= 1'b0;
            serial_in_line <= (tcnt == 5'h01) ? ~serial_in_line : tsh[15];
            tsh <= {tsh[14:0], 1'b0};
            tcnt <= tcnt - 5'h01;
        end
    end
    // Receive 16 bits after each sync; a sync on the last bit chains the next word.
    always @(posedge core_clk) begin
        rx_stb <= 1'b0;
        if (serial_clk && rcnt == 5'h00) begin
            rcnt <= out_frame_sync ? 5'h10 : 5'h00;
        end else if (serial_clk) begin
            rx_word <= {rx_word[14:0], serial_out_oe ? serial_out_line : ~rx_word[0]};
            rcnt <= (rcnt == 5'h01 && out_frame_sync) ? 5'h10 : rcnt - 5'h01;
            rx_stb <= rcnt == 5'h01;
        end
    end
endmodule : afs_host_port
`default_nettype wire

/* sim/afs_serial_ctrl_tb.sv */
// Self-checking bench for the serial mode control block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module afs_serial_ctrl_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic tx_go = 1'b0;
    logic [15:0] tx_word = 16'h0000;
    logic serial_in_line, in_frame_sync, serial_clk, out_frame_sync, serial_out_line;
    logic serial_out_oe, adc_ready, tx_busy, rx_stb, ref_power, data_mode, mixed_mode;
    logic reset_busy;
    logic [15:0] rx_word;
    logic [63:0] ctrl_regs;
    logic [5:0] chan_power;
    logic [15:0] rx_q[$];
    int n_fail = 0;
    int num_checks = 0;
    int i;
    int nz;
    afs_serial_ctrl afs_serial_ctrl_i (
        .core_clk(core_clk), .rst(rst), .port_enable_pin(1'b1), .serial_in_line(serial_in_line),
        .in_frame_sync(in_frame_sync), .serial_clk(serial_clk), .out_frame_sync(out_frame_sync),
        .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .adc_valid(1'b1),
        .adc_data(16'hffff), .adc_ready(adc_ready), .ctrl_regs(ctrl_regs),
        .chan_power(chan_power), .ref_power(ref_power), .data_mode(data_mode),
        .mixed_mode(mixed_mode), .reset_busy(reset_busy));
    afs_host_port afs_host_port_i (
        .core_clk(core_clk), .serial_clk(serial_clk), .tx_go(tx_go), .tx_word(tx_word),
        .tx_busy(tx_busy), .serial_in_line(serial_in_line), .in_frame_sync(in_frame_sync),
        .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
        .out_frame_sync(out_frame_sync), .rx_stb(rx_stb), .rx_word(rx_word));
    // 50 ns clock.
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    // Keep every word the host receives.
    always @(posedge core_clk) begin
        if (rx_stb) begin
            rx_q.push_back(rx_word);
        end
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results
    // A wait that ran out counts as a mismatch.
    task automatic timeout();
        n_fail++;
        $display("wrong value wait expected done seen timeout");
        results();
    endtask : timeout
    // Control word: flag, write, device address, register, data.
    function automatic logic [15:0] cw(input logic [2:0] dev, input logic [2:0] rg,
        input logic [7:0] d);
        cw = {1'b1, 1'b0, dev, rg, d};
    endfunction : cw
    // Sends one word and gives the block time to decode it.
    task automatic send(input logic [15:0] w);
        @(negedge core_clk);
        tx_word = w;
        tx_go = 1'b1;
        for (i = 0; i < 100 && tx_busy !== 1'b1; i++) @(negedge core_clk);
        if (i == 100) timeout();
        tx_go = 1'b0;
        for (i = 0; i < 400 && tx_busy !== 1'b0; i++) @(negedge core_clk);
        if (i == 400) timeout();
        repeat (4) @(negedge core_clk);
    endtask : send
    // Writes a power register and compares the effective power.
    task automatic pwr(input logic [2:0] rg, input logic [7:0] d, input logic [5:0] ch,
        input logic rf);
        send(cw(3'h0, rg, d));
        `CHK("channel power", ch, chan_power)
        `CHK("reference power", rf, ref_power)
    endtask : pwr
    // Waits for a nonzero word at the host and compares it.
    task automatic expect_rx(input string what, input logic [15:0] exp);
        rx_q.delete();
        for (i = 0; i < 9000 && !(rx_q.size() > 0 && rx_q[$] !== 16'h0000); i++)
            @(negedge core_clk);
        if (i == 9000) timeout();
        `CHK(what, exp, rx_q[$])
    endtask : expect_rx
    // Hardware reset held for 16 cycles.
    task automatic hw_reset();
        rst = 1'b1;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        `CHK("registers after reset", 64'h0, ctrl_regs)
        `CHK("mode after reset", 1'b0, data_mode)
    endtask : hw_reset
    initial begin
        hw_reset();
        for (i = 0; i < 5000 && out_frame_sync !== 1'b1; i++) @(negedge core_clk);
        `CHK("first frame delay", 1'b1, i >= 2060 && i < 2100)
        $display("test reset done");
        pwr(afs_pkg::REG_C, 8'h21, 6'h3f, 1'b1);
        pwr(afs_pkg::REG_C, 8'h20, 6'h00, 1'b1);
        pwr(afs_pkg::REG_C, 8'h00, 6'h00, 1'b0);
        pwr(afs_pkg::REG_D, 8'h07, 6'h00, 1'b0);
        pwr(afs_pkg::REG_D, 8'h08, 6'h01, 1'b1);
        nz = 0;
        foreach (rx_q[j]) nz += int'(rx_q[j] !== 16'h0000);
        `CHK("own words echoed", 0, nz)
        send(cw(3'h3, afs_pkg::REG_B, 8'h55));
        expect_rx("forwarded word", cw(3'h2, afs_pkg::REG_B, 8'h55));
        `CHK("registers", 64'h0000_0000_0800_0000, ctrl_regs)
        $display("test program mode done");
        send(cw(3'h0, afs_pkg::REG_A, 8'h80));
        `CHK("registers after soft reset", 64'h0, ctrl_regs)
        send(cw(3'h0, afs_pkg::REG_A, 8'h03));
        `CHK("mixed mode", 1'b1, mixed_mode)
        send(cw(3'h0, afs_pkg::REG_D, 8'h08) & 16'h7fff);
        `CHK("data word as control", 8'h00, ctrl_regs[31:24])
        send(cw(3'h0, afs_pkg::REG_D, 8'h08));
        `CHK("power in mixed mode", 6'h01, chan_power)
        expect_rx("mixed sample", 16'h7fff);
        $display("test mixed mode done");
        send(cw(3'h0, afs_pkg::REG_A, 8'h01));
        `CHK("data mode", 2'b10, {data_mode, mixed_mode})
        send(cw(3'h0, afs_pkg::REG_D, 8'h00));
        send(cw(3'h0, afs_pkg::REG_A, 8'h80));
        `CHK("locked registers", 16'h0801, {ctrl_regs[31:24], ctrl_regs[7:0]})
        expect_rx("buffered mixed sample", 16'h7fff);
        expect_rx("buffered mixed sample", 16'h7fff);
        expect_rx("data sample", 16'hffff);
        hw_reset();
        $display("test data mode done");
        results();
    end
endmodule : afs_serial_ctrl_tb
`default_nettype wire
